// [spi_port_pkg.sv]
// Constants and types shared by the serial port modules
package spi_port_pkg;

	// Register offsets in data space, and the shift down to I/O space
	localparam logic [7:0] CONTROL_OFFSET = 8'h4C;
	localparam logic [7:0] STATUS_OFFSET  = 8'h4D;
	localparam logic [7:0] DATA_OFFSET    = 8'h4E;
	localparam logic [7:0] IO_SPACE_SHIFT = 8'h20;
	localparam logic [7:0] IO_SPACE_TOP   = 8'h3F;

	// Control register fields
	localparam int IRQ_ENABLE_BIT   = 7;
	localparam int PORT_ENABLE_BIT  = 6;
	localparam int LSB_FIRST_BIT    = 5;
	localparam int MASTER_BIT       = 4;
	localparam int IDLE_POLARITY_BIT = 3;
	localparam int SAMPLE_PHASE_BIT = 2;
	localparam int RATE_HIGH_BIT    = 1;
	localparam int RATE_LOW_BIT     = 0;

	// Status register fields
	localparam int DONE_FLAG_BIT    = 7;
	localparam int COLLISION_BIT    = 6;
	localparam int DOUBLER_BIT      = 0;

	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [7:0] DATA_RESET    = 8'h00;

	// Half of each clock divisor: /4 /16 /64 /128, doubled /2 /8 /32 /64
	localparam int HALF_WIDTH = 7;
	localparam logic [HALF_WIDTH-1:0] HALF_DIV4   = 7'h02;
	localparam logic [HALF_WIDTH-1:0] HALF_DIV16  = 7'h08;
	localparam logic [HALF_WIDTH-1:0] HALF_DIV64  = 7'h20;
	localparam logic [HALF_WIDTH-1:0] HALF_DIV128 = 7'h40;
	localparam logic [HALF_WIDTH-1:0] HALF_DIV2   = 7'h01;
	localparam logic [HALF_WIDTH-1:0] HALF_DIV8   = 7'h04;
	localparam logic [HALF_WIDTH-1:0] HALF_DIV32  = 7'h10;

	// Bits per transfer and the count of the last clock edge of a transfer
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] LAST_EDGE = 4'hF;

	// Register selected by an access
	typedef enum logic [1:0] {SEL_NONE, SEL_CONTROL, SEL_STATUS, SEL_DATA} reg_sel_t;

	// Transfer engine state
	typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;

endpackage : spi_port_pkg

// [rate_if.sv]
// Link between the transfer engine and the clock rate divider
`timescale 1ns/10ps
`default_nettype none
interface rate_if;
	logic       run;
	logic       doubler;
	logic [1:0] code;
	logic       tick;
	modport engine (output run, output doubler, output code, input tick);
	modport divider (input run, input doubler, input code, output tick);
endinterface : rate_if
`default_nettype wire

// [pin_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Pins and synchronised copies
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] pins_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	always_comb begin
		next_st        = st;
		next_st.first  = pins;
		next_st.second = st.first;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pins_sync = st.second;
endmodule : pin_sync
`default_nettype wire

// [rate_divider.sv]
// Clock rate divider giving one enable pulse per half serial clock period
`timescale 1ns/10ps
`default_nettype none
module rate_divider
	import spi_port_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Engine side
	rate_if.divider   rate
);
	typedef struct packed {
		logic [HALF_WIDTH-1:0] count;
		logic                  tick;
	} div_state_t;

	div_state_t st;
	div_state_t next_st;

	function automatic logic [HALF_WIDTH-1:0] half_period(input logic dbl, input logic [1:0] c);
		logic [HALF_WIDTH-1:0] h;
		h = HALF_DIV4;
		case ({dbl, c})
			3'b000: h = HALF_DIV4;
			3'b001: h = HALF_DIV16;
			3'b010: h = HALF_DIV64;
			3'b011: h = HALF_DIV128;
			3'b100: h = HALF_DIV2;
			3'b101: h = HALF_DIV8;
			3'b110: h = HALF_DIV32;
			default: h = HALF_DIV64;
		endcase
		return h;
	endfunction : half_period

	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		// Held at zero while stopped so the first half period is whole
		if (!rate.run) begin
			next_st.count = '0;
		end else if (st.count + 7'h01 >= half_period(rate.doubler, rate.code)) begin
			next_st.count = '0;
			next_st.tick  = 1'b1;
		end else begin
			next_st.count = st.count + 7'h01;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rate.tick = st.tick;
endmodule : rate_divider
`default_nettype wire

// [spi_master_slave_port.sv]
// Byte serial port, master or slave, with control, status and data registers
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_port
	import spi_port_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// CPU register access
	input  wire logic [7:0] bus_addr,
	input  wire logic       bus_io_space,
	input  wire logic       bus_rd,
	input  wire logic       bus_wr,
	input  wire logic [7:0] bus_wdata,
	output logic      [7:0] bus_rdata,
	// Interrupt
	input  wire logic       global_irq_enable,
	input  wire logic       irq_vector_taken,
	output logic            irq,
	// Pin directions from the port logic, one means output
	input  wire logic       dir_sck_out,
	input  wire logic       dir_mosi_out,
	input  wire logic       dir_miso_out,
	input  wire logic       dir_ss_out,
	// Serial clock pin
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe_n,
	// Master out pin
	input  wire logic       mosi_in,
	output logic            mosi_out,
	output logic            mosi_oe_n,
	// Master in pin
	input  wire logic       miso_in,
	output logic            miso_out,
	output logic            miso_oe_n,
	// Slave select pin, active low
	input  wire logic       ss_n_in
);
	import spi_port_pkg::*;

	typedef struct packed {
		logic [7:0]  ctrl;
		logic        doubler;
		logic        done;
		logic        collision_bit;
		logic        arm_done;
		logic        arm_collision_bit;
		logic [7:0]  rx_buf;
		logic [7:0]  tx;
		logic [7:0]  rx;
		logic [3:0]  edge_cnt;
		logic        sck_lvl;
		logic        sck_prev;
		xfer_state_t state;
		logic [7:0]  rdata;
	} port_state_t;

	port_state_t st;
	port_state_t next_st;

	rate_if rate ();

	logic [3:0] pins_sync;
	logic       sck_s;
	logic       mosi_s;
	logic       miso_s;
	logic       ss_n_s;

	// Slave clock is sampled, so it must stay below a quarter of clk
	pin_sync #(.WIDTH(4)) u_sync (
		.clk       (clk),
		.rst       (rst),
		.pins      ({sck_in, mosi_in, miso_in, ss_n_in}),
		.pins_sync (pins_sync)
	);

	assign sck_s  = pins_sync[3];
	assign mosi_s = pins_sync[2];
	assign miso_s = pins_sync[1];
	assign ss_n_s = pins_sync[0];

	rate_divider u_div (
		.clk  (clk),
		.rst  (rst),
		.rate (rate.divider)
	);

	// Maps an access to a register in either address space
	function automatic reg_sel_t decode(input logic [7:0] a, input logic io);
		logic [7:0] da;
		reg_sel_t   s;
		da = a + IO_SPACE_SHIFT;
		s  = SEL_NONE;
		if (io && a > IO_SPACE_TOP) begin
			s = SEL_NONE;
		end else if ((io ? da : a) == CONTROL_OFFSET) begin
			s = SEL_CONTROL;
		end else if ((io ? da : a) == STATUS_OFFSET) begin
			s = SEL_STATUS;
		end else if ((io ? da : a) == DATA_OFFSET) begin
			s = SEL_DATA;
		end
		return s;
	endfunction : decode

	reg_sel_t rd_sel;
	reg_sel_t wr_sel;
	logic     enabled;
	logic     is_master;
	logic     lsb_first;
	logic     idle_polarity_bit;
	logic     sample_phase_bit;
	logic     mode_fault;
	logic     slave_sel;
	logic     out_bit;
	logic     in_bit;
	logic     data_access;
	logic     status_read;
	logic     edge_seen;
	logic     leading;
	logic     sample_edge;
	logic     setup_edge;
	logic     byte_done;
	logic     sck_new;

	assign rd_sel      = bus_rd ? decode(bus_addr, bus_io_space) : SEL_NONE;
	assign wr_sel      = bus_wr ? decode(bus_addr, bus_io_space) : SEL_NONE;
	assign enabled     = st.ctrl[PORT_ENABLE_BIT];
	assign is_master   = enabled && st.ctrl[MASTER_BIT];
	assign lsb_first   = st.ctrl[LSB_FIRST_BIT];
	assign idle_polarity_bit        = st.ctrl[IDLE_POLARITY_BIT];
	assign sample_phase_bit        = st.ctrl[SAMPLE_PHASE_BIT];
	assign mode_fault  = is_master && !dir_ss_out && !ss_n_s;
	assign slave_sel   = enabled && !st.ctrl[MASTER_BIT] && !ss_n_s;
	assign out_bit     = lsb_first ? st.tx[0] : st.tx[BYTE_BITS-1];
	assign in_bit      = is_master ? miso_s : mosi_s;
	assign data_access = (rd_sel == SEL_DATA) || (wr_sel == SEL_DATA);
	assign status_read = (rd_sel == SEL_STATUS);

	// Master edges come from the divider, slave edges from the pin
	assign sck_new   = is_master ? !st.sck_lvl : sck_s;
	assign edge_seen = is_master ? (st.state == ST_SHIFT && rate.tick)
	                             : (slave_sel && sck_s != st.sck_prev);
	assign leading   = (sck_new != idle_polarity_bit);
	assign sample_edge = edge_seen && (leading == !sample_phase_bit);
	assign setup_edge  = edge_seen && (leading == sample_phase_bit) && st.edge_cnt != 4'h0;
	assign byte_done   = edge_seen && st.edge_cnt == LAST_EDGE;

	assign rate.run     = is_master && st.state == ST_SHIFT;
	assign rate.doubler = st.doubler;
	assign rate.code    = st.ctrl[RATE_HIGH_BIT:RATE_LOW_BIT];

	always_comb begin
		next_st          = st;
		next_st.sck_prev = sck_s;

		// Register reads answer one cycle later from a flop
		if (rd_sel == SEL_CONTROL) begin
			next_st.rdata = st.ctrl;
		end else if (rd_sel == SEL_STATUS) begin
			next_st.rdata = {st.done, st.collision_bit, 5'h00, st.doubler};
		end else if (rd_sel == SEL_DATA) begin
			next_st.rdata = st.rx_buf;
		end

		// Two-step flag clear: arm on status read, fire on data access
		if (data_access) begin
			if (st.arm_done) begin
				next_st.done = 1'b0;
			end
			if (st.arm_collision_bit) begin
				next_st.done = 1'b0;
				next_st.collision_bit = 1'b0;
			end
			next_st.arm_done = 1'b0;
			next_st.arm_collision_bit = 1'b0;
		end
		if (status_read) begin
			next_st.arm_done = st.done;
			next_st.arm_collision_bit = st.collision_bit;
		end
		if (irq_vector_taken) begin
			next_st.done = 1'b0;
		end

		// Control and status writes; flags are not writable
		if (wr_sel == SEL_CONTROL) begin
			next_st.ctrl = bus_wdata;
		end else if (wr_sel == SEL_STATUS) begin
			next_st.doubler = bus_wdata[DOUBLER_BIT];
		end

		// Data write loads a byte and starts it in master mode, or collides with one in flight
		if (wr_sel == SEL_DATA) begin
			if (st.state == ST_SHIFT || (slave_sel && st.edge_cnt != 4'h0)) begin
				next_st.collision_bit = 1'b1;
			end else begin
				next_st.tx = bus_wdata;
				if (is_master) begin
					next_st.state    = ST_SHIFT;
					next_st.edge_cnt = 4'h0;
					next_st.sck_lvl  = idle_polarity_bit;
				end
			end
		end

		// Idle master clock follows the polarity bit
		if (st.state == ST_IDLE) begin
			next_st.sck_lvl = idle_polarity_bit;
		end else if (is_master && rate.tick) begin
			next_st.sck_lvl = !st.sck_lvl;
		end

		// Shift engine, shared by both roles
		if (sample_edge) begin
			next_st.rx = lsb_first ? {in_bit, st.rx[7:1]} : {st.rx[6:0], in_bit};
		end
		if (setup_edge) begin
			next_st.tx = lsb_first ? {1'b0, st.tx[7:1]} : {st.tx[6:0], 1'b0};
		end
		if (edge_seen) begin
			next_st.edge_cnt = st.edge_cnt + 4'h1;
		end
		if (byte_done) begin
			next_st.rx_buf   = st.rx;
			next_st.done     = 1'b1;
			next_st.state    = ST_IDLE;
			next_st.edge_cnt = 4'h0;
			if (sample_edge) begin
				next_st.rx_buf = next_st.rx;
			end
		end

		// Deselected slave drops any partial byte at once
		if (enabled && !st.ctrl[MASTER_BIT] && ss_n_s) begin
			next_st.edge_cnt = 4'h0;
			next_st.rx       = 8'h00;
		end

		// Another master selected us: step down to slave
		if (mode_fault) begin
			next_st.ctrl[MASTER_BIT] = 1'b0;
			next_st.done             = 1'b1;
			next_st.state            = ST_IDLE;
			next_st.edge_cnt         = 4'h0;
		end

		// Disabling the port abandons any transfer
		if (!enabled) begin
			next_st.state    = ST_IDLE;
			next_st.edge_cnt = 4'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st          <= '0;
			st.ctrl     <= CONTROL_RESET;
			st.doubler  <= STATUS_RESET[DOUBLER_BIT];
			st.rx_buf   <= DATA_RESET;
			st.state    <= ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign bus_rdata = st.rdata;
	assign irq       = st.done && st.ctrl[IRQ_ENABLE_BIT] && global_irq_enable;
	assign sck_out   = st.sck_lvl;
	assign sck_oe_n  = !(is_master && dir_sck_out);
	assign mosi_out  = out_bit;
	assign mosi_oe_n = !(is_master && dir_mosi_out);
	assign miso_out  = out_bit;
	assign miso_oe_n = !(slave_sel && dir_miso_out);

endmodule : spi_master_slave_port
`default_nettype wire

// [spi_port_fix_note_unused.sv]
// Empty source unit with no logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [spi_port_chk.sv]
// Port-level checker for the serial port
`timescale 1ns/10ps
`default_nettype none
module spi_port_chk
	import spi_port_pkg::*;
(
	// Clock and reset
	input wire logic       clk, rst,
	// Register access
	input wire logic [7:0] bus_addr, bus_wdata, bus_rdata,
	input wire logic       bus_io_space, bus_rd, bus_wr, global_irq_enable, irq,
	// Pins
	input wire logic       dir_sck_out, dir_mosi_out, dir_miso_out,
	input wire logic       sck_out, sck_oe_n, mosi_oe_n, miso_oe_n
);
	localparam logic [6:0] HT [8] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, HALF_DIV128,
		HALF_DIV2, HALF_DIV8, HALF_DIV32, HALF_DIV64};
	logic [7:0] a, ctl, gap;
	logic [2:0] cw;
	logic       dbl, prev, tog;
	// Shadow of software writes; master bit is not trusted after a mode fault
	assign a = bus_io_space ? bus_addr + IO_SPACE_SHIFT : bus_addr;
	assign tog = sck_out != prev;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl <= 8'h00;
			dbl <= 1'b0;
			prev <= 1'b0;
			gap <= 8'h00;
			cw <= 3'h0;
		end else begin
			if (bus_wr && a == CONTROL_OFFSET)
				ctl <= bus_wdata;
			if (bus_wr && a == STATUS_OFFSET)
				dbl <= bus_wdata[0];
			prev <= sck_out;
			gap <= tog ? 8'h00 : gap + {7'h00, gap != 8'hFF};
			// Writes may move the idle level, so their edges are not timed
			cw <= bus_wr ? 3'h0 : cw + {2'h0, cw != 3'h7};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_IRQ_CAUSE: assert property (irq |-> ctl[IRQ_ENABLE_BIT] && global_irq_enable)
		else $error("interrupt without enable");
	AST_SCK_DRIVE: assert property (!sck_oe_n |-> ctl[PORT_ENABLE_BIT] && dir_sck_out)
		else $error("clock driven while disabled");
	AST_MOSI_DRIVE: assert property (!mosi_oe_n |-> ctl[PORT_ENABLE_BIT] && dir_mosi_out)
		else $error("data out driven while disabled");
	AST_MISO_DRIVE: assert property (!miso_oe_n |-> ctl[6] && dir_miso_out && sck_oe_n)
		else $error("slave output driven out of slave mode");
	AST_SCK_HALF: assert property (tog && sck_out == ctl[3] && cw > 3'h3 && !sck_oe_n
		|-> gap == {1'b0, HT[{dbl, ctl[1:0]}]} - 8'h01)
		else $error("clock half period wrong");
	AST_RDATA_HOLD: assert property (!bus_rd |=> $stable(bus_rdata))
		else $error("read data moved without a read");
	AST_STATUS_ZERO: assert property (bus_rd && a == STATUS_OFFSET |=> bus_rdata[5:1] == 5'h00)
		else $error("unused status bits not zero");
	AST_CTL_BACK: assert property (bus_rd && !bus_wr && a == CONTROL_OFFSET
		|=> (bus_rdata & 8'hEF) == ($past(ctl) & 8'hEF))
		else $error("control readback wrong");
	cover property (irq);
	cover property (tog && sck_out == ctl[3] && cw > 3'h3);
	cover property (!miso_oe_n);
endmodule : spi_port_chk
bind spi_master_slave_port spi_port_chk i_spi_port_chk (.clk, .rst, .bus_addr, .bus_wdata,
	.bus_rdata, .bus_io_space, .bus_rd, .bus_wr, .global_irq_enable, .irq, .dir_sck_out,
	.dir_mosi_out, .dir_miso_out, .sck_out, .sck_oe_n, .mosi_oe_n, .miso_oe_n);
`default_nettype wire

// [spi_far_end.sv]
// Behavioural serial slave on the far side of the port
`timescale 1ns/10ps
`default_nettype none
module spi_far_end (
	input  wire logic       sck, sel_n, mosi, idle_polarity_bit, sample_phase_bit, lsb,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic      [7:0] rx
);
	logic q = 1'b0;
	int   e, k;
	// Released line shows the inverse of the last bit driven
	assign miso = sel_n ? ~q : q;
	always @(negedge sel_n) begin
		e = 0;
		k = 0;
		if (!sample_phase_bit) begin
			q = lsb ? tx[0] : tx[7];
			k = 1;
		end
	end
	always @(sck) if (!sel_n) begin
		e++;
		if ((e % 2 == 1) != sample_phase_bit)
			rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		else if (k < 8) begin
			q = lsb ? tx[k] : tx[7-k];
			k++;
		end
	end
endmodule : spi_far_end
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the serial port
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import spi_port_pkg::*;
	logic clk = 1'b0, rst = 1'b1, io = 1'b1, rd = 1'b0, wr = 1'b0, gie = 1'b0, vec = 1'b0;
	logic ds = 1'b1, dm = 1'b1, dmi = 1'b0, dss = 1'b1, ssn = 1'b1, psel = 1'b1;
	logic idle_polarity_bit = 1'b0, sample_phase_bit = 1'b0, lsb = 1'b0, bsck = 1'b0, bmosi = 1'b1;
	logic [7:0] adr = 8'h00, wd = 8'h00, rdat, ptx = 8'h00, prx, v, c;
	logic irq, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, pmiso;
	logic [31:0] lf = 32'd73825;
	int n_mismatch = 0, tests_run = 0, cyc = 0, h, t;
	int divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
	wire logic sck_w = sck_oe_n ? bsck : sck;
	wire logic mosi_w = mosi_oe_n ? bmosi : mosi;
	wire logic miso_w = miso_oe_n ? pmiso : miso;
	spi_master_slave_port i_spi_master_slave_port (.clk, .rst, .bus_addr(adr), .bus_io_space(io),
		.bus_rd(rd), .bus_wr(wr), .bus_wdata(wd), .bus_rdata(rdat), .global_irq_enable(gie),
		.irq_vector_taken(vec), .irq, .dir_sck_out(ds), .dir_mosi_out(dm), .dir_miso_out(dmi),
		.dir_ss_out(dss), .sck_in(sck_w), .sck_out(sck), .sck_oe_n, .mosi_in(mosi_w),
		.mosi_out(mosi), .mosi_oe_n, .miso_in(miso_w), .miso_out(miso), .miso_oe_n, .ss_n_in(ssn));
	spi_far_end i_spi_far_end (.sck(sck_w), .sel_n(psel), .mosi(mosi_w), .idle_polarity_bit, .sample_phase_bit, .lsb,
		.tx(ptx), .miso(pmiso), .rx(prx));
	always #12.5 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic summarize;
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One strobe cycle, then read data taken once it stands
	task automatic acc(input logic [7:0] off, input logic w, input logic [7:0] d);
		@(posedge clk);
		#2;
		adr = io ? off - IO_SPACE_SHIFT : off;
		wd = d;
		wr = w;
		rd = !w;
		@(posedge clk);
		#2;
		wr = 1'b0;
		rd = 1'b0;
		@(posedge clk);
		#2 v = rdat;
	endtask : acc
	task automatic wait_done;
		t = 0;
		do begin
			acc(STATUS_OFFSET, 1'b0, 8'h00);
			t++;
		end while (v[7] !== 1'b1 && t < 500);
	endtask : wait_done
	task automatic tog(output int n);
		logic s;
		s = sck;
		n = 0;
		while (sck === s && n < 300) begin
			@(posedge clk);
			#2 n++;
		end
	endtask : tog
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		#2 rst = 1'b0;
		acc(CONTROL_OFFSET, 1'b0, 8'h00);
		chk("ctl_reset", v, CONTROL_RESET);
		acc(STATUS_OFFSET, 1'b0, 8'h00);
		chk("sts_reset", v, STATUS_RESET);
		io = 1'b0;
		lf = lfsr(lf);
		c = lf[7:0] & 8'hBF;
		acc(CONTROL_OFFSET, 1'b1, c);
		acc(CONTROL_OFFSET, 1'b0, 8'h00);
		chk("ctl_rw", v, c);
		acc(8'h4F, 1'b0, 8'h00);
		chk("unmapped", v, c);
		io = 1'b1;
		acc(CONTROL_OFFSET + IO_SPACE_SHIFT, 1'b0, 8'h00);
		chk("io_high", v, c);
		acc(STATUS_OFFSET, 1'b1, 8'hFF);
		acc(STATUS_OFFSET, 1'b0, 8'h00);
		chk("sts_rw", v, 8'h01);
		io = 1'b0;
		for (int r = 0; r < 8; r++) begin
			acc(STATUS_OFFSET, 1'b1, {7'h00, r[2]});
			acc(CONTROL_OFFSET, 1'b1, 8'h50 | {6'h00, r[1:0]});
			acc(DATA_OFFSET, 1'b1, 8'hA5);
			tog(h);
			tog(h);
			chk("rate", 8'(2 * h), 8'(divs[r]));
			wait_done;
			chk("idle_low", {7'h00, sck}, 8'h00);
			acc(DATA_OFFSET, 1'b0, 8'h00);
		end
		acc(STATUS_OFFSET, 1'b1, 8'h00);
		for (int m = 0; m < 8; m++) begin
			{idle_polarity_bit, sample_phase_bit, lsb} = m[2:0];
			gie = m[0];
			io = m[1];
			lf = lfsr(lf);
			ptx = lf[15:8];
			acc(CONTROL_OFFSET, 1'b1, {2'b11, lsb, 1'b1, idle_polarity_bit, sample_phase_bit, 2'b01});
			psel = 1'b0;
			acc(DATA_OFFSET, 1'b1, lf[7:0]);
			wait_done;
			chk("irq", {7'h00, irq}, {7'h00, gie});
			chk("idle", {7'h00, sck}, {7'h00, idle_polarity_bit});
			chk("far_rx", prx, lf[7:0]);
			acc(DATA_OFFSET, 1'b0, 8'h00);
			chk("rx", v, ptx);
			acc(STATUS_OFFSET, 1'b0, 8'h00);
			chk("done_clr", v, 8'h00);
			psel = 1'b1;
		end
		{idle_polarity_bit, sample_phase_bit, lsb} = 3'b000;
		io = 1'b0;
		acc(CONTROL_OFFSET, 1'b1, 8'h51);
		psel = 1'b0;
		acc(DATA_OFFSET, 1'b1, 8'h3C);
		acc(DATA_OFFSET, 1'b1, 8'hC3);
		wait_done;
		chk("collide", v, 8'hC0);
		chk("far_first", prx, 8'h3C);
		acc(DATA_OFFSET, 1'b0, 8'h00);
		acc(STATUS_OFFSET, 1'b0, 8'h00);
		chk("both_clr", v, 8'h00);
		gie = 1'b1;
		acc(CONTROL_OFFSET, 1'b1, 8'hD1);
		acc(DATA_OFFSET, 1'b1, 8'h00);
		t = 0;
		while (irq !== 1'b1 && t < 400) begin
			@(posedge clk);
			#2 t++;
		end
		vec = 1'b1;
		@(posedge clk);
		#2 vec = 1'b0;
		chk("vec_irq", {7'h00, irq}, 8'h00);
		acc(STATUS_OFFSET, 1'b0, 8'h00);
		chk("vec_sts", v, 8'h00);
		psel = 1'b1;
		dss = 1'b0;
		ssn = 1'b0;
		repeat (4) @(posedge clk);
		#2 ssn = 1'b1;
		acc(STATUS_OFFSET, 1'b0, 8'h00);
		chk("fault_done", v, 8'h80);
		acc(CONTROL_OFFSET, 1'b0, 8'h00);
		chk("fault_master_select_bit", v, 8'hC1);
		acc(DATA_OFFSET, 1'b0, 8'h00);
		dmi = 1'b1;
		ssn = 1'b0;
		repeat (4) @(posedge clk);
		#2 chk("slave_oe", {7'h00, miso_oe_n}, 8'h00);
		ssn = 1'b1;
		repeat (4) @(posedge clk);
		#2 chk("slave_off", {7'h00, miso_oe_n}, 8'h01);
		// Bench acts as an external master in mode 0, clock at an eighth of clk
		lf = lfsr(lf);
		acc(CONTROL_OFFSET, 1'b1, 8'h40);
		acc(DATA_OFFSET, 1'b1, lf[15:8]);
		ssn = 1'b0;
		for (int b = 7; b >= 0; b--) begin
			bmosi = lf[b];
			repeat (4) @(posedge clk);
			#2 c[b] = miso_w;
			bsck = 1'b1;
			repeat (4) @(posedge clk);
			#2 bsck = 1'b0;
		end
		repeat (4) @(posedge clk);
		#2 ssn = 1'b1;
		chk("slave_tx", c, lf[15:8]);
		acc(STATUS_OFFSET, 1'b0, 8'h00);
		chk("slave_done", v, 8'h80);
		acc(DATA_OFFSET, 1'b0, 8'h00);
		chk("slave_rx", v, lf[7:0]);
		summarize();
	end
endmodule : testbench
`default_nettype wire
